// ==== verilog/ppb_core.sv ====
// Buffer status flags and split-buffer master addressing of the parallel port.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`default_nettype none
module ppb_core
   import ppb_pkg::*;
#(
   parameter int SLOTS = 4
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             irq,
   input  wire logic        host_wr_n,
   input  wire logic        host_rd_n,
   input  wire logic [1:0]  host_slot,
   input  wire logic [7:0]  host_wdata,
   output logic      [7:0]  host_rdata,
   output logic             txn_start,
   output logic             txn_is_write,
   output logic      [15:0] txn_address,
   output logic             txn_select_two,
   output logic             txn_select_one,
   input  wire logic        txn_rdata_valid,
   input  wire logic [15:0] txn_rdata
);
   if (SLOTS != 4) begin : g_bad_slots
      $error("ppb_core serves exactly four slots");
   end

   // ****************************************
   // Host strobe synchronisers
   // ****************************************
   logic [2:0] wr_sync_q;
   logic [2:0] rd_sync_q;
   logic [2:0][1:0] slot_sync_q;
   logic [2:0][7:0] data_sync_q;
   logic       wr_level_q;
   logic       rd_level_q;
   logic       host_wr_pulse;
   logic       host_rd_pulse;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_sync_q  <= 3'h7;
         rd_sync_q  <= 3'h7;
         slot_sync_q <= 6'h00;
         data_sync_q <= 24'h000000;
         wr_level_q <= 1'b1;
         rd_level_q <= 1'b1;
      end else begin
         wr_sync_q <= {wr_sync_q[1:0], host_wr_n};
         rd_sync_q <= {rd_sync_q[1:0], host_rd_n};
         slot_sync_q <= {slot_sync_q[1:0], host_slot};
         data_sync_q <= {data_sync_q[1:0], host_wdata};
         if (wr_sync_q[1] == wr_sync_q[2]) begin
            wr_level_q <= wr_sync_q[2];
         end
         if (rd_sync_q[1] == rd_sync_q[2]) begin
            rd_level_q <= rd_sync_q[2];
         end
      end
   end

   // A strobe counts when its agreed level falls from high to low.
   assign host_wr_pulse = wr_level_q & ~wr_sync_q[2] & (wr_sync_q[1] == wr_sync_q[2]);
   assign host_rd_pulse = rd_level_q & ~rd_sync_q[2] & (rd_sync_q[1] == rd_sync_q[2]);

   // ****************************************
   // Control registers
   // ****************************************
   logic [31:0] control_q;
   logic [15:0] write_target_address_q;
   logic [15:0] read_target_address_q;
   logic [15:0] rcap_q;
   logic [15:0] outdata_q;
   logic [15:0] shared_q;
   logic [3:0]  irq_mask_q;
   logic        split_en;
   logic        slave_en;
   ppb_csf_e    chip_select_function;
   logic        bus_wr;
   logic        bus_rd;

   assign bus_wr   = reg_wr;
   assign bus_rd   = reg_rd;
   assign split_en = control_q[PPB_CTL_SPLIT];
   assign slave_en = control_q[PPB_CTL_SLAVE];
   assign chip_select_function      = ppb_csf_e'(control_q[PPB_CTL_CSF_LO +: 2]);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control_q  <= 32'h0000_0000;
         write_target_address_q    <= PPB_RST_ADDR;
         read_target_address_q    <= PPB_RST_ADDR;
         outdata_q  <= PPB_RST_DATA;
         irq_mask_q <= 4'h0;
      end else if (bus_wr) begin
         case (reg_addr)
            PPB_OFS_CONTROL:  control_q  <= reg_wdata;
            PPB_OFS_WRITE_TARGET_ADDRESS:    write_target_address_q    <= reg_wdata[15:0];
            PPB_OFS_READ_TARGET_ADDRESS:    read_target_address_q    <= reg_wdata[15:0];
            PPB_OFS_OUTDATA:  outdata_q  <= reg_wdata[15:0];
            PPB_OFS_IRQ_MASK: irq_mask_q <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Read capture and shared input data
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rcap_q   <= PPB_RST_DATA;
         shared_q <= PPB_RST_DATA;
      end else begin
         if (bus_wr && reg_addr == PPB_OFS_RDATA) begin
            rcap_q <= reg_wdata[15:0];
         end
         if (bus_wr && reg_addr == PPB_OFS_SHARED) begin
            shared_q <= reg_wdata[15:0];
         end
         if (txn_rdata_valid) begin
            if (split_en) begin
               rcap_q <= txn_rdata;
            end else begin
               shared_q <= txn_rdata;
            end
         end
      end
   end

   // ****************************************
   // Split-buffer transaction launch
   // ****************************************
   ppb_target_s wtarget;
   ppb_target_s rtarget;
   logic        msb_write;
   logic        launch;

   always_comb begin
      wtarget.address = {2'b00, write_target_address_q[13:0]};
      wtarget.select_two = (chip_select_function == PPB_CSF_BOTH) || (chip_select_function == PPB_CSF_CS2) ? write_target_address_q[15] : 1'b0;
      if (chip_select_function == PPB_CSF_ADDR) begin
         wtarget.address[15] = write_target_address_q[15];
      end
      wtarget.select_one = (chip_select_function == PPB_CSF_BOTH) ? write_target_address_q[14] : 1'b0;
      if (chip_select_function == PPB_CSF_ADDR || chip_select_function == PPB_CSF_CS2) begin
         wtarget.address[14] = write_target_address_q[14];
      end
      rtarget.address = {2'b00, read_target_address_q[13:0]};
      rtarget.select_two = (chip_select_function == PPB_CSF_BOTH) || (chip_select_function == PPB_CSF_CS2) ? read_target_address_q[15] : 1'b0;
      if (!rtarget.select_two) begin
         rtarget.address[15] = read_target_address_q[15];
      end
      rtarget.select_one = (chip_select_function == PPB_CSF_BOTH) ? read_target_address_q[14] : 1'b0;
      if (chip_select_function != PPB_CSF_BOTH) begin
         rtarget.address[14] = read_target_address_q[14];
      end
   end

   assign msb_write = bus_wr && reg_addr == PPB_OFS_OUTDATA;
   assign launch = msb_write && split_en && !slave_en;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txn_start      <= 1'b0;
         txn_is_write   <= 1'b0;
         txn_address    <= PPB_RST_ADDR;
         txn_select_two <= 1'b0;
         txn_select_one <= 1'b0;
      end else begin
         txn_start <= launch;
         if (launch) begin
            txn_is_write   <= 1'b1;
            txn_address    <= wtarget.address;
            txn_select_two <= wtarget.select_two;
            txn_select_one <= wtarget.select_one;
         end else if (bus_rd && reg_addr == PPB_OFS_RDATA && split_en && !slave_en) begin
            txn_is_write   <= 1'b0;
            txn_address    <= rtarget.address;
            txn_select_two <= rtarget.select_two;
            txn_select_one <= rtarget.select_one;
         end
      end
   end

   // ****************************************
   // Slave buffers and status flags
   // ****************************************
   logic [7:0] inbuf_q  [SLOTS];
   logic [7:0] outbuf_q [SLOTS];
   logic [SLOTS-1:0] in_full_q;
   logic [SLOTS-1:0] out_empty_q;
   logic       overflow_q;
   logic       underflow_q;
   logic       host_wr_ok;
   logic       host_rd_ok;

   assign host_wr_ok = host_wr_pulse && slave_en;
   assign host_rd_ok = host_rd_pulse && slave_en;

   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               inbuf_q[g]     <= 8'h00;
               outbuf_q[g]    <= 8'h00;
               in_full_q[g]   <= PPB_RST_IN_FULL[g];
               out_empty_q[g] <= PPB_RST_OUT_EMPTY[g];
            end else begin
               if (host_wr_ok && slot_sync_q[2] == 2'(g) && !in_full_q[g]) begin
                  inbuf_q[g]   <= data_sync_q[2];
                  in_full_q[g] <= 1'b1;
               end else if (bus_rd && reg_addr == PPB_OFS_INBUF0 + 8'(4 * g)) begin
                  in_full_q[g] <= 1'b0;
               end
               if (bus_wr && reg_addr == PPB_OFS_OUTBUF0 + 8'(4 * g)) begin
                  outbuf_q[g]    <= reg_wdata[7:0];
                  out_empty_q[g] <= 1'b0;
               end else if (host_rd_ok && slot_sync_q[2] == 2'(g)) begin
                  out_empty_q[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         host_rdata <= 8'h00;
      end else if (host_rd_ok) begin
         host_rdata <= outbuf_q[slot_sync_q[2]];
      end
   end

   logic set_ovf;
   logic set_unf;
   logic clr_ovf;
   logic clr_unf;

   assign set_ovf = host_wr_ok && in_full_q[slot_sync_q[2]];
   assign set_unf = host_rd_ok && out_empty_q[slot_sync_q[2]];
   assign clr_ovf = bus_wr && reg_addr == PPB_OFS_STATUS && !reg_wdata[PPB_ST_IN_OVERFLOW];
   assign clr_unf = bus_wr && reg_addr == PPB_OFS_STATUS && !reg_wdata[PPB_ST_OUT_UNDERFL];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overflow_q  <= 1'b0;
         underflow_q <= 1'b0;
      end else begin
         if (set_ovf) begin
            overflow_q <= 1'b1;
         end else if (clr_ovf) begin
            overflow_q <= 1'b0;
         end
         if (set_unf) begin
            underflow_q <= 1'b1;
         end else if (clr_unf) begin
            underflow_q <= 1'b0;
         end
      end
   end

   logic [15:0] status;
   always_comb begin
      status = 16'h0000;
      status[PPB_ST_IN_ALL_FULL] = &in_full_q;
      status[PPB_ST_IN_OVERFLOW] = overflow_q;
      status[PPB_ST_IN_SLOT_LO +: 4] = in_full_q;
      status[PPB_ST_OUT_ALL_EMPT] = &out_empty_q;
      status[PPB_ST_OUT_UNDERFL] = underflow_q;
      status[PPB_ST_OUT_SLOT_LO +: 4] = out_empty_q;
   end

   // ****************************************
   // Interrupts
   // ****************************************
   logic [3:0] irq_stat_q;
   logic [3:0] irq_set;
   assign irq_set = {txn_rdata_valid && split_en, launch, set_unf, set_ovf};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_stat_q <= 4'h0;
      end else if (bus_rd && reg_addr == PPB_OFS_IRQ_STAT) begin
         irq_stat_q <= irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (bus_rd) begin
         case (reg_addr)
            PPB_OFS_STATUS:   reg_rdata <= {16'h0000, status};
            PPB_OFS_WRITE_TARGET_ADDRESS:    reg_rdata <= {16'h0000, write_target_address_q};
            PPB_OFS_READ_TARGET_ADDRESS:    reg_rdata <= {16'h0000, read_target_address_q};
            PPB_OFS_RDATA:    reg_rdata <= {16'h0000, rcap_q};
            PPB_OFS_CONTROL:  reg_rdata <= control_q;
            PPB_OFS_OUTDATA:  reg_rdata <= {16'h0000, outdata_q};
            PPB_OFS_SHARED:   reg_rdata <= {16'h0000, shared_q};
            PPB_OFS_IRQ_STAT: reg_rdata <= {28'h0000000, irq_stat_q};
            PPB_OFS_IRQ_MASK: reg_rdata <= {28'h0000000, irq_mask_q};
            PPB_OFS_INBUF0:          reg_rdata <= {24'h000000, inbuf_q[0]};
            PPB_OFS_INBUF0 + 8'h04:  reg_rdata <= {24'h000000, inbuf_q[1]};
            PPB_OFS_INBUF0 + 8'h08:  reg_rdata <= {24'h000000, inbuf_q[2]};
            PPB_OFS_INBUF0 + 8'h0C:  reg_rdata <= {24'h000000, inbuf_q[3]};
            default:          reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/ppb_pkg.sv ====
// Package for the parallel port buffer status and split-buffer addressing block.
`default_nettype none
package ppb_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] PPB_OFS_STATUS   = 8'h00;
   localparam logic [7:0] PPB_OFS_WRITE_TARGET_ADDRESS    = 8'h04;
   localparam logic [7:0] PPB_OFS_READ_TARGET_ADDRESS    = 8'h08;
   localparam logic [7:0] PPB_OFS_RDATA    = 8'h0C;
   localparam logic [7:0] PPB_OFS_CONTROL  = 8'h10;
   localparam logic [7:0] PPB_OFS_OUTDATA  = 8'h14;
   localparam logic [7:0] PPB_OFS_SHARED   = 8'h18;
   localparam logic [7:0] PPB_OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] PPB_OFS_IRQ_MASK = 8'h20;
   localparam logic [7:0] PPB_OFS_INBUF0   = 8'h30;
   localparam logic [7:0] PPB_OFS_OUTBUF0  = 8'h40;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int PPB_ST_IN_ALL_FULL  = 15;
   localparam int PPB_ST_IN_OVERFLOW  = 14;
   localparam int PPB_ST_IN_SLOT_LO   = 8;
   localparam int PPB_ST_OUT_ALL_EMPT = 7;
   localparam int PPB_ST_OUT_UNDERFL  = 6;
   localparam int PPB_ST_OUT_SLOT_LO  = 0;
   localparam int PPB_CTL_CSF_LO      = 6;
   localparam int PPB_CTL_WIDE        = 10;
   localparam int PPB_CTL_SLAVE       = 16;
   localparam int PPB_CTL_SPLIT       = 17;
   localparam int PPB_IRQ_OVERFLOW    = 0;
   localparam int PPB_IRQ_UNDERFLOW   = 1;
   localparam int PPB_IRQ_START       = 2;
   localparam int PPB_IRQ_CAPTURE     = 3;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] PPB_RST_ADDR = 16'h0000;
   localparam logic [15:0] PPB_RST_DATA = 16'h0000;
   localparam logic [3:0]  PPB_RST_OUT_EMPTY = 4'hF;
   localparam logic [3:0]  PPB_RST_IN_FULL   = 4'h0;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      PPB_CSF_ADDR   = 2'b00,
      PPB_CSF_CS2    = 2'b01,
      PPB_CSF_BOTH   = 2'b10,
      PPB_CSF_RSVD   = 2'b11
   } ppb_csf_e;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ppb_bus_req_s;
   typedef struct packed {
      logic        select_two;
      logic        select_one;
      logic [15:0] address;
   } ppb_target_s;
endpackage
`default_nettype wire

// ==== test/ppb_core_assertions.sv ====
// Concurrent checks on the register and launch ports of the core.
`default_nettype none
module ppb_core_assertions
   import ppb_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        txn_start,
   input wire logic        txn_is_write,
   input wire logic [15:0] txn_address,
   input wire logic        txn_select_two,
   input wire logic        txn_select_one
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ctl_q;
   logic [15:0] wad_q;
   logic [1:0]  chip_select_function;
   logic        go;
   // Shadow copies of the control and write address registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_q <= 32'h0;
         wad_q <= 16'h0;
      end else if (reg_wr) begin
         if (reg_addr == PPB_OFS_CONTROL) ctl_q <= reg_wdata;
         if (reg_addr == PPB_OFS_WRITE_TARGET_ADDRESS) wad_q <= reg_wdata[15:0];
      end
   end
   assign chip_select_function = ctl_q[PPB_CTL_CSF_LO +: 2];
   assign go  = reg_wr && reg_addr == PPB_OFS_OUTDATA && ctl_q[PPB_CTL_SPLIT] && !ctl_q[PPB_CTL_SLAVE];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ****
   // Assertions
   // ****
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero");
   a_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) <= PPB_OFS_RDATA |->
      reg_rdata[31:16] == 16'h0) else $error("upper half not zero");
   a_start_go: assert property (go |=> txn_start)
      else $error("no launch");
   a_start_cause: assert property (txn_start |-> $past(go))
      else $error("launch without cause");
   a_write_addr: assert property (txn_start |-> txn_is_write && txn_address[13:0] == wad_q[13:0])
      else $error("bad write target");
   a_sel_two: assert property (txn_start |->
      txn_select_two == (wad_q[15] && (chip_select_function == PPB_CSF_CS2 || chip_select_function == PPB_CSF_BOTH))) else $error("bad select two");
   a_sel_one: assert property (txn_start |-> txn_select_one == (wad_q[14] && chip_select_function == PPB_CSF_BOTH))
      else $error("bad select one");
   a_addr_top: assert property (txn_start && chip_select_function == PPB_CSF_ADDR |-> txn_address[15:14] == wad_q[15:14])
      else $error("bad top address");
   c_launch: cover property (txn_start);
   c_read: cover property ($past(reg_rd) && reg_rdata != 32'h0);
   c_both: cover property (txn_start && txn_select_one);
endmodule
`default_nettype wire

// ==== test/ppb_host_model.sv ====
// Behavioural host and peripheral on the far side of the core.
`default_nettype none
module ppb_host_model (
   input  wire logic   clk,
   output logic        host_wr_n,
   output logic        host_rd_n,
   output logic [1:0]  host_slot,
   output logic [7:0]  host_wdata,
   output logic        txn_rdata_valid,
   output logic [15:0] txn_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_wr_n = 1'h1;
      host_rd_n = 1'h1;
      host_slot = 2'h0;
      host_wdata = 8'h5A;
      txn_rdata_valid = 1'h0;
      txn_rdata = 16'hA5A5;
   end
   // Each strobe level is held four clocks so the synchroniser sees one edge.
   task automatic strobe(input logic wr, input logic [1:0] s, input logic [7:0] d);
      @(posedge clk);
      host_slot <= s;
      host_wdata <= d;
      @(posedge clk);
      host_wr_n <= !wr;
      host_rd_n <= wr;
      repeat (4) @(posedge clk);
      host_wr_n <= 1'h1;
      host_rd_n <= 1'h1;
      repeat (4) @(posedge clk);
      host_wdata <= ~d;
   endtask
   // Released data shows the inverse so a stale value is never taken for a new one.
   task automatic ret(input logic [15:0] d);
      @(posedge clk);
      txn_rdata_valid <= 1'h1;
      txn_rdata <= d;
      @(posedge clk);
      txn_rdata_valid <= 1'h0;
      txn_rdata <= ~d;
   endtask
endmodule
`default_nettype wire

// ==== test/ppb_core_bench.sv ====
// Self-checking bench of the buffer status and split addressing core.
`default_nettype none
module ppb_core_bench
   import ppb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, reg_wr, reg_rd, irq, host_wr_n, host_rd_n, txn_start;
   logic        txn_is_write, txn_select_two, txn_select_one, txn_rdata_valid;
   logic [1:0]  host_slot;
   logic [7:0]  reg_addr, host_wdata, host_rdata;
   logic [15:0] txn_address, txn_rdata;
   logic [31:0] reg_wdata, reg_rdata;
   int          n_errors, samples_checked, n_start, n;
   ppb_core i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .host_wr_n,
      .host_rd_n, .host_slot, .host_wdata, .host_rdata, .txn_start, .txn_is_write, .txn_address,
      .txn_select_two, .txn_select_one, .txn_rdata_valid, .txn_rdata);
   ppb_host_model i_host (.clk, .host_wr_n, .host_rd_n, .host_slot, .host_wdata, .txn_rdata_valid,
      .txn_rdata);
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (txn_start === 1'h1) n_start++;
   // ****
   // Tasks
   // ****
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic conclude;
      $display("Checks made: %0d, mismatches: %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      conclude();
   end
   initial begin
      rst = 1'h1;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      rd(PPB_OFS_STATUS, 32'h8F);
      rd(8'hF0, 32'h0);
      for (int i = 1; i < 4; i++) begin
         rd(8'(4 * i), 32'h0);
         wr(8'(4 * i), 32'hFFFFFFFF);
         rd(8'(4 * i), 32'hFFFF);
      end
      wr(PPB_OFS_CONTROL, 32'h10000);
      wr(PPB_OFS_IRQ_MASK, 32'h0);
      for (int i = 0; i < 4; i++) begin
         i_host.strobe(1'h1, 2'(i), 8'(8'hA0 + i));
         rd(PPB_OFS_STATUS, {16'h0, i == 3, 3'h0, 4'((2 << i) - 1), 8'h8F});
      end
      i_host.strobe(1'h1, 2'h0, 8'h55);
      rd(PPB_OFS_STATUS, 32'hCF8F);
      settle();
      chk(irq, 32'h0);
      wr(PPB_OFS_IRQ_MASK, 32'h1);
      settle();
      chk(irq, 32'h1);
      rd(PPB_OFS_IRQ_STAT, 32'h1);
      settle();
      chk(irq, 32'h0);
      wr(PPB_OFS_STATUS, 32'h0);
      rd(PPB_OFS_STATUS, 32'h8F8F);
      rd(PPB_OFS_INBUF0 + 8'h08, 32'hA2);
      rd(PPB_OFS_STATUS, 32'h0B8F);
      wr(PPB_OFS_OUTBUF0 + 8'h04, 32'h3C);
      rd(PPB_OFS_STATUS, 32'h0B0D);
      i_host.strobe(1'h0, 2'h1, 8'h00);
      chk(host_rdata, 32'h3C);
      rd(PPB_OFS_STATUS, 32'h0B8F);
      i_host.strobe(1'h0, 2'h1, 8'h00);
      rd(PPB_OFS_STATUS, 32'h0BCF);
      rd(PPB_OFS_IRQ_STAT, 32'h2);
      wr(PPB_OFS_STATUS, 32'h0);
      wr(PPB_OFS_CONTROL, 32'h0);
      i_host.strobe(1'h1, 2'h2, 8'h77);
      rd(PPB_OFS_STATUS, 32'h0B8F);
      for (int c = 0; c < 3; c++) begin
         wr(PPB_OFS_CONTROL, 32'h20000 | (c << 6));
         wr(PPB_OFS_WRITE_TARGET_ADDRESS, 32'hC123);
         n = n_start;
         wr(PPB_OFS_OUTDATA, 32'hA5);
         settle();
         chk(n_start, n + 1);
         chk({txn_is_write, txn_select_two, txn_select_one, c == 0 ? txn_address[15] : 1'h1,
            c == 2 ? 1'h1 : txn_address[14], txn_address[13:0]}, {1'h1, c != 0, c == 2, 16'hC123});
      end
      wr(PPB_OFS_READ_TARGET_ADDRESS, 32'hCABC);
      rd(PPB_OFS_RDATA, 32'hFFFF);
      settle();
      chk({txn_is_write, txn_select_two, txn_select_one, txn_address[13:0]}, {3'h3, 14'h0ABC});
      i_host.ret(16'h5A3C);
      rd(PPB_OFS_RDATA, 32'h5A3C);
      rd(PPB_OFS_SHARED, 32'h0);
      wr(PPB_OFS_CONTROL, 32'h0);
      n = n_start;
      wr(PPB_OFS_OUTDATA, 32'h1);
      i_host.ret(16'h1234);
      rd(PPB_OFS_SHARED, 32'h1234);
      rd(PPB_OFS_RDATA, 32'h5A3C);
      chk(n_start, n);
      conclude();
   end
endmodule
bind ppb_core ppb_core_assertions u_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .txn_start, .txn_is_write, .txn_address, .txn_select_two, .txn_select_one);
`default_nettype wire
